/* rtl/bir_params.svh */
/*
 Constants for the board interrupt router: line counts, fixed request numbers, legal steering mask, steering reset code.
 Assumes inclusion by bare name from the router sources.
*/
`ifndef BIR_PARAMS_SVH
`define BIR_PARAMS_SVH
`define BIR_NUM_LINES 8
`define BIR_NUM_LEGACY 16
`define BIR_NUM_ADV 24
`define BIR_ADV_BASE 16
`define BIR_IRQ_TIMER 0
`define BIR_IRQ_KBD 1
`define BIR_IRQ_CASCADE 2
`define BIR_IRQ_SER2 3
`define BIR_IRQ_SER1 4
`define BIR_IRQ_PAR2 5
`define BIR_IRQ_FLOPPY 6
`define BIR_IRQ_PAR1 7
`define BIR_IRQ_RTC 8
`define BIR_IRQ_MOUSE 12
`define BIR_IRQ_FPU 13
`define BIR_IRQ_IDE1 14
`define BIR_IRQ_IDE2 15
`define BIR_STEER_OK 16'hdef8
`define BIR_STEER_RST 5'h1f
`endif

/* rtl/bir_pkg.sv */
/*
 Types shared by the board interrupt router.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package bir_pkg;
   typedef enum logic [0:0] {
      BIR_MODE_LEGACY = 1'b0,
      BIR_MODE_ADV = 1'b1
   } bir_mode_e;
   // One conventional slot's four lines, active low
   typedef struct packed {
      logic intd_n;
      logic intc_n;
      logic intb_n;
      logic inta_n;
   } bir_slot_s;
   // Fixed legacy sources, active high
   typedef struct packed {
      logic timer;
      logic kbd;
      logic ser1;
      logic ser2;
      logic par1;
      logic par2;
      logic floppy;
      logic rtc;
      logic mouse;
      logic fpu;
      logic ide1;
      logic ide2;
      logic chan_check;
   } bir_legacy_src_s;
   // Presence and reassignment of configurable sources
   typedef struct packed {
      logic mouse_present;
      logic ide1_present;
      logic ide2_present;
      logic [4:0] ser1_irq;
      logic [4:0] ser2_irq;
      logic [4:0] par1_irq;
   } bir_cfg_s;
   typedef logic [4:0] bir_irq_t;
endpackage
`default_nettype wire

/* rtl/bir_sync.sv */
/*
 Two-stage synchroniser bank for asynchronous interrupt pins.
 Assumes inputs may change at any time relative to clk_i.
*/
`default_nettype none
module bir_sync #(
   parameter int WIDTH = 8,
   parameter logic RST_VAL = 1'b1
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Data
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s1_next;
   logic [WIDTH-1:0] s2_next;

   always_comb
   begin
      s1_next = d_i;
      s2_next = s1_reg;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         s1_reg <= {WIDTH{RST_VAL}};
         s2_reg <= {WIDTH{RST_VAL}};
      end
      else
      begin
         s1_reg <= s1_next;
         s2_reg <= s2_next;
      end
   end

   assign q_o = s2_reg;
endmodule
`default_nettype wire

/* rtl/bir_router.sv */
/*
 Board interrupt router: merges PCI slot and onboard lines onto eight steering lines,
 then delivers them through the legacy (IRQ 0-15) or advanced (IRQ 0-23) controller path.
 Assumes asynchronous active-low INTx pins and steering set by configuration software.
*/
`include "bir_params.svh"
`default_nettype none
module bir_router #(
   parameter int NUM_SLOTS = 4,
   parameter int NUM_DYN = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Configuration
   input wire bir_pkg::bir_mode_e mode_i,
   input wire logic [`BIR_NUM_LINES*5-1:0] steer_i,
   input wire bir_pkg::bir_cfg_s cfg_i,
   // PCI interrupt pins, active low
   input wire bir_pkg::bir_slot_s [NUM_SLOTS-1:0] slot_i,
   input wire logic fw_inta_n_i,
   // Dynamically assigned sources (USB, SATA, PCIe)
   input wire logic [NUM_DYN-1:0] dyn_req_i,
   input wire logic [NUM_DYN*5-1:0] dyn_irq_i,
   // Fixed legacy sources
   input wire bir_pkg::bir_legacy_src_s leg_i,
   // Controller outputs
   output logic [`BIR_NUM_LEGACY-1:0] legacy_irq_o,
   output logic [`BIR_NUM_ADV-1:0] adv_irq_o,
   output logic nmi_o,
   output logic [`BIR_NUM_LINES-1:0] steering_line_o
);
   ////////////////////////////////////////////////////////////////////////
   // Synchronise all pins
   localparam int PIN_W = NUM_SLOTS * 4 + 1;
   logic [PIN_W-1:0] pins_sync;
   logic [$bits(bir_pkg::bir_legacy_src_s)-1:0] leg_sync;
   logic [NUM_DYN-1:0] dyn_sync;

   bir_sync #(.WIDTH(PIN_W), .RST_VAL(1'b1)) u_pin_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i({fw_inta_n_i, slot_i}),
      .q_o(pins_sync)
   );
   bir_sync #(.WIDTH($bits(bir_pkg::bir_legacy_src_s)), .RST_VAL(1'b0)) u_leg_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(leg_i),
      .q_o(leg_sync)
   );
   bir_sync #(.WIDTH(NUM_DYN), .RST_VAL(1'b0)) u_dyn_sync (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .d_i(dyn_req_i),
      .q_o(dyn_sync)
   );

   bir_pkg::bir_slot_s [NUM_SLOTS-1:0] sl;
   bir_pkg::bir_legacy_src_s ls;
   logic fw_n;
   assign sl = pins_sync[PIN_W-2:0];
   assign fw_n = pins_sync[PIN_W-1];
   assign ls = leg_sync;

   // Legal legacy steering target
   function automatic logic steer_ok(input bir_pkg::bir_irq_t n);
      logic [15:0] ok;
      ok = `BIR_STEER_OK;
      steer_ok = (n < 5'h10) && ok[n[3:0]];
   endfunction

   // One-hot decode of a request number
   function automatic logic [`BIR_NUM_ADV-1:0] irq_hot(input bir_pkg::bir_irq_t n);
      irq_hot = '0;
      if (n < 5'h18)
         irq_hot[n] = 1'b1;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Steering lines and request fan-in
   logic [`BIR_NUM_LINES-1:0] line_reg, line_next;
   logic [`BIR_NUM_LEGACY-1:0] leg_reg, leg_next;
   logic [`BIR_NUM_ADV-1:0] adv_reg, adv_next;
   logic nmi_reg, nmi_next;

   always_comb
   begin
      logic [`BIR_NUM_LINES-1:0] lw;
      logic [`BIR_NUM_ADV-1:0] req;
      bir_pkg::bir_irq_t sel;
      lw = '0;
      req = '0;
      sel = '0;
      // Wired-AND of active-low lines becomes an OR of assertions
      lw[1] = ~fw_n | ~sl[2].intc_n;
      lw[0] = ~sl[2].intd_n;
      lw[2] = ~sl[2].inta_n | ~sl[3].intb_n;
      lw[3] = ~sl[2].intb_n | ~sl[3].inta_n;
      lw[4] = ~sl[0].intd_n | ~sl[1].intc_n;
      lw[5] = ~sl[0].inta_n | ~sl[1].intb_n | ~sl[3].intc_n;
      lw[6] = ~sl[0].intb_n | ~sl[1].inta_n | ~sl[3].intd_n;
      lw[7] = ~sl[0].intc_n | ~sl[1].intd_n;
      line_next = lw;

      // Fixed, configured and dynamic assignments
      req[`BIR_IRQ_TIMER] = ls.timer;
      req[`BIR_IRQ_KBD] = ls.kbd;
      req[`BIR_IRQ_RTC] = ls.rtc;
      req[`BIR_IRQ_FPU] = ls.fpu;
      req[`BIR_IRQ_FLOPPY] = ls.floppy;
      req[`BIR_IRQ_PAR2] = ls.par2;
      req = req | irq_hot(cfg_i.ser1_irq) & {`BIR_NUM_ADV{ls.ser1}};
      req = req | irq_hot(cfg_i.ser2_irq) & {`BIR_NUM_ADV{ls.ser2}};
      req = req | irq_hot(cfg_i.par1_irq) & {`BIR_NUM_ADV{ls.par1}};
      if (cfg_i.mouse_present)
         req[`BIR_IRQ_MOUSE] = req[`BIR_IRQ_MOUSE] | ls.mouse;
      if (cfg_i.ide1_present)
         req[`BIR_IRQ_IDE1] = req[`BIR_IRQ_IDE1] | ls.ide1;
      if (cfg_i.ide2_present)
         req[`BIR_IRQ_IDE2] = req[`BIR_IRQ_IDE2] | ls.ide2;
      for (int d = 0; d < NUM_DYN; d++)
         req = req | irq_hot(dyn_irq_i[d*5 +: 5]) & {`BIR_NUM_ADV{dyn_sync[d]}};

      // Lines reach requests 16-23 directly only in advanced mode
      if (mode_i == bir_pkg::BIR_MODE_ADV)
      begin
         for (int i = 0; i < `BIR_NUM_LINES; i++)
            req[`BIR_ADV_BASE + i] = req[`BIR_ADV_BASE + i] | lw[i];
      end
      else
      begin
         for (int i = 0; i < `BIR_NUM_LINES; i++)
         begin
            sel = steer_i[i*5 +: 5];
            // Shared targets simply OR together
            if (steer_ok(sel) && lw[i])
               req[sel] = 1'b1;
         end
         // Cascade input on the master reflects any slave request
         // Overrides any source aimed at 2, so the cascade cannot be faked
         req[`BIR_IRQ_CASCADE] = |req[15:8];
         req[`BIR_NUM_ADV-1:`BIR_ADV_BASE] = '0;
      end
      leg_next = (mode_i == bir_pkg::BIR_MODE_LEGACY) ? req[`BIR_NUM_LEGACY-1:0] : '0;
      adv_next = (mode_i == bir_pkg::BIR_MODE_ADV) ? req : '0;
      nmi_next = ls.chan_check;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         line_reg <= '0;
         leg_reg <= '0;
         adv_reg <= '0;
         nmi_reg <= 1'b0;
      end
      else
      begin
         line_reg <= line_next;
         leg_reg <= leg_next;
         adv_reg <= adv_next;
         nmi_reg <= nmi_next;
      end
   end

   assign legacy_irq_o = leg_reg;
   assign adv_irq_o = adv_reg;
   assign nmi_o = nmi_reg;
   assign steering_line_o = line_reg;

   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_path_exclusive: assert property (@(posedge clk_i) disable iff (rst_i)
      !(|legacy_irq_o && |adv_irq_o)) else $error("both controller paths active");
   a_legacy_range: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(mode_i) == bir_pkg::BIR_MODE_LEGACY |-> adv_irq_o == '0) else $error("advanced path in legacy mode");
   a_adv_map: assert property (@(posedge clk_i) disable iff (rst_i)
      mode_i == bir_pkg::BIR_MODE_ADV ##1 1'b1 |-> (adv_irq_o[23:16] & steering_line_o) == steering_line_o)
      else $error("line not on its request");
   a_fw_line: assert property (@(posedge clk_i) disable iff (rst_i)
      !fw_n |=> steering_line_o[1]) else $error("1394 not on line B");
   a_slot1_a: assert property (@(posedge clk_i) disable iff (rst_i)
      !sl[0].inta_n |=> steering_line_o[5]) else $error("slot 1 INTA not on line F");
   a_line_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      (&pins_sync) |=> steering_line_o == '0) else $error("line asserted with all pins high");
   a_timer_fixed: assert property (@(posedge clk_i) disable iff (rst_i)
      ls.timer && mode_i == bir_pkg::BIR_MODE_LEGACY |=> legacy_irq_o[0]) else $error("timer not on request 0");
   a_nmi_map: assert property (@(posedge clk_i) disable iff (rst_i)
      ls.chan_check |=> nmi_o) else $error("channel check missed");
   a_mouse_gate: assert property (@(posedge clk_i) disable iff (rst_i)
      ls.mouse && cfg_i.mouse_present && mode_i == bir_pkg::BIR_MODE_LEGACY |=> legacy_irq_o[12])
      else $error("mouse not on request 12");
   a_cascade_flag: assert property (@(posedge clk_i) disable iff (rst_i)
      legacy_irq_o[2] == |legacy_irq_o[15:8]) else $error("cascade request out of step");
   a_legacy_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
      $past(mode_i) == bir_pkg::BIR_MODE_ADV |-> legacy_irq_o == '0) else $error("legacy path in advanced mode");
   a_slot2_merge: assert property (@(posedge clk_i) disable iff (rst_i)
      !sl[1].intd_n || !sl[0].intc_n |=> steering_line_o[7]) else $error("line H not merged");
   a_dyn_route: assert property (@(posedge clk_i) disable iff (rst_i)
      dyn_sync[0] && dyn_irq_i[4:0] == 5'h09 && mode_i == bir_pkg::BIR_MODE_LEGACY |=> legacy_irq_o[9])
      else $error("dynamic source not on its request");
endmodule
`default_nettype wire

/* sim/bir_pci_model.sv */
/*
 Source model: INTx pins of four conventional slots and the 1394 line.
 Assumes the bench picks sources through act_i, changed at clock edges.
*/
`default_nettype none
module bir_pci_model (
   // Clock
   input wire logic clk_i,
   // Active sources, bit slot*4+pin, bit 16 the 1394 line
   input wire logic [16:0] act_i,
   // Pins
   output var bir_pkg::bir_slot_s [3:0] slot_o,
   output logic fw_inta_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins float to the pull-up level
   always_ff @(posedge clk_i)
   begin
      slot_o <= ~act_i[15:0];
      fw_inta_n_o <= ~act_i[16];
   end
endmodule
`default_nettype wire

/* sim/bir_router_tb.sv */
/*
 Self-checking bench for the interrupt router.
 Assumes package, router and source model compiled first.
*/
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module bir_router_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   bir_pkg::bir_mode_e mode_i = bir_pkg::BIR_MODE_ADV;
   logic [39:0] steer_i = '0;
   bir_pkg::bir_cfg_s cfg_i = {3'h7, 5'h04, 5'h03, 5'h07};
   logic [16:0] act = '0;
   bir_pkg::bir_slot_s [3:0] slot;
   logic fw_n;
   logic [3:0] dyn_req_i = '0;
   logic [19:0] dyn_irq_i = '0;
   bir_pkg::bir_legacy_src_s leg_i = '0;
   logic [15:0] legacy_irq_o;
   logic [23:0] adv_irq_o;
   logic nmi_o;
   logic [7:0] steering_line_o;
   int err_count = 0;
   int checks_done = 0;
   int cycles = 0;
   int line_of[17] = '{5, 6, 7, 4, 6, 5, 4, 7, 2, 3, 1, 0, 3, 2, 5, 6, 1};
   int ok_tab[11] = '{3, 4, 5, 6, 7, 9, 10, 11, 12, 14, 15};
   int bad_tab[6] = '{0, 1, 2, 8, 13, 16};
   int leg_tab[13] = '{-1, 15, 14, 13, 12, 8, 6, 5, 7, 3, 4, 1, 0};
   bir_router i_bir_router (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode_i), .steer_i(steer_i),
      .cfg_i(cfg_i), .slot_i(slot), .fw_inta_n_i(fw_n), .dyn_req_i(dyn_req_i), .dyn_irq_i(dyn_irq_i),
      .leg_i(leg_i), .legacy_irq_o(legacy_irq_o), .adv_irq_o(adv_irq_o), .nmi_o(nmi_o),
      .steering_line_o(steering_line_o));
   bir_pci_model i_bir_pci_model (.clk_i(clk_i), .act_i(act), .slot_o(slot), .fw_inta_n_o(fw_n));
   always #5 clk_i = ~clk_i;
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         tally_and_finish();
      end
   end
   // Cascade request follows any of 8 to 15
   function automatic logic [15:0] exp_l(input int n);
      return (16'h0001 << n) | ((n >= 8) ? 16'h0004 : 16'h0000);
   endfunction
   // Model plus pin path take four edges; five leaves margin
   task automatic settle();
      repeat (5) @(posedge clk_i);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_adv_map();
      for (int i = 0; i < 17; i++)
      begin
         @(posedge clk_i);
         act <= 17'h00001 << i;
         settle();
         `CHK(steering_line_o, 8'h01 << line_of[i])
         `CHK(adv_irq_o[23:16], 8'h01 << line_of[i])
      end
      @(posedge clk_i);
      act <= 17'h00012;
      settle();
      `CHK(adv_irq_o[22], 1'b1)
      @(posedge clk_i);
      act <= 17'h00010;
      settle();
      `CHK(adv_irq_o[22], 1'b1)
      @(posedge clk_i);
      act <= '0;
      settle();
      `CHK(adv_irq_o, 24'h000000)
   endtask
   task automatic t_leg_steer();
      @(posedge clk_i);
      mode_i <= bir_pkg::BIR_MODE_LEGACY;
      // Line A has this one source alone, as a fast card wants
      act <= 17'h00800;
      for (int i = 0; i < 11; i++)
      begin
         @(posedge clk_i);
         steer_i[4:0] <= 5'(ok_tab[i]);
         settle();
         `CHK(legacy_irq_o, exp_l(ok_tab[i]))
         `CHK(adv_irq_o[23:16], 8'h00)
      end
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clk_i);
         steer_i[4:0] <= 5'(bad_tab[i]);
         settle();
         `CHK(legacy_irq_o, 16'h0000)
      end
      @(posedge clk_i);
      steer_i[9:0] <= {5'h09, 5'h09};
      act <= 17'h10800;
      settle();
      `CHK(legacy_irq_o, exp_l(9))
      @(posedge clk_i);
      act <= 17'h10000;
      settle();
      `CHK(legacy_irq_o, exp_l(9))
      @(posedge clk_i);
      act <= '0;
   endtask
   task automatic t_fixed();
      for (int b = 0; b < 13; b++)
      begin
         @(posedge clk_i);
         leg_i <= 13'h0001 << b;
         settle();
         `CHK(nmi_o, (b == 0))
         `CHK(legacy_irq_o, (b == 0) ? 16'h0000 : exp_l(leg_tab[b]))
      end
      @(posedge clk_i);
      cfg_i[17:15] <= 3'h0;
      leg_i <= 13'h0016;
      settle();
      `CHK(legacy_irq_o, 16'h0000)
      @(posedge clk_i);
      cfg_i.ser1_irq <= 5'h0a;
      leg_i <= 13'h0400;
      settle();
      `CHK(legacy_irq_o, exp_l(10))
      @(posedge clk_i);
      leg_i <= '0;
   endtask
   task automatic t_dyn();
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk_i);
         dyn_irq_i[k*5+:5] <= 5'(9 + k);
         dyn_req_i <= 4'h1 << k;
         settle();
         `CHK(legacy_irq_o, exp_l(9 + k))
      end
      // Advanced path reaches requests above 15 from a dynamic source
      @(posedge clk_i);
      mode_i <= bir_pkg::BIR_MODE_ADV;
      dyn_irq_i[19:15] <= 5'h17;
      settle();
      `CHK(adv_irq_o, 24'h800000)
      `CHK(legacy_irq_o, 16'h0000)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("mismatches %0d, comparisons %0d", err_count, checks_done);
      if (err_count == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      `CHK({legacy_irq_o, adv_irq_o, nmi_o, steering_line_o}, 49'h0)
      t_adv_map();
      t_leg_steer();
      t_fixed();
      t_dyn();
      tally_and_finish();
   end
endmodule
`default_nettype wire
